// >>> core/rsc_pkg.sv
// Purpose: Shared constants, types and helpers of the remote station command handler.
// Assumes: Two nodes occupied; station word memory of 2048 words of 16 bits.
// Notes: Both ends, the checker and the bench import this package.
package rsc_pkg;
  localparam int RSC_WORDS = 2048;
  localparam logic [15:0] RSC_ADDR_MAX = 16'h07EF;
  localparam logic [10:0] RSC_BASE = 11'h014;
  localparam logic [10:0] RSC_LINK_LAST = 11'h047;
  localparam logic [10:0] RSC_OFS_RY = 11'h00A;
  localparam logic [7:0] RSC_CODE_RWRITE = 8'h05;
  localparam logic [7:0] RSC_CODE_MONITOR = 8'h06;
  localparam logic [7:0] RSC_CODE_PWRITE = 8'h08;
  localparam logic [7:0] RSC_MAX_RWRITE = 8'h03;
  localparam logic [7:0] RSC_MAX_MONITOR = 8'h06;
  localparam logic [7:0] RSC_MAX_PWRITE = 8'h03;
  localparam int STB_DONE = 0;
  localparam int STB_TOUCH = 5;
  localparam int STB_TAG = 7;
  localparam int STB_INIT = 9;
  localparam int STB_ERR = 10;
  localparam int STB_READY = 11;
  localparam int RQB_DISP = 0;
  localparam int RQB_MON = 1;
  localparam int RQB_PW = 2;
  localparam int RQB_INIT = 9;
  localparam int RQB_ERST = 10;
  localparam logic [15:0] RSC_ERR_CODE = 16'h0001;
  localparam logic [15:0] RSC_ERR_COUNT = 16'h0002;
  localparam logic [15:0] RSC_ERR_ADDR = 16'h0003;
  localparam logic [15:0] RSC_ERR_LINK = 16'h0004;
  localparam logic [7:0] RSC_A_CMD0 = 8'h00;
  localparam logic [7:0] RSC_A_CTRL = 8'h20;
  localparam logic [7:0] RSC_A_STATUS = 8'h24;
  localparam logic [7:0] RSC_A_RESP = 8'h28;
  localparam logic [7:0] RSC_A_USERIN0 = 8'h30;
  localparam logic [7:0] RSC_A_USEROUT0 = 8'h40;
  localparam logic [7:0] RSC_A_INTSTAT = 8'h50;
  localparam logic [7:0] RSC_A_INTMASK = 8'h54;
  localparam int CTB_GO = 0;
  localparam int CTB_PW = 1;
  localparam int CTB_MON = 2;
  localparam int CTB_ERST = 3;
  localparam int CTB_INIT = 4;
  localparam int STB_BUSY = 16;
  localparam int INB_DONE = 0;
  localparam int INB_ERR = 1;
  localparam int INB_TAG = 2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_DONE = 3'b100
  } rsc_sstate_t;

  typedef enum logic [2:0] {
    M_IDLE = 3'b001,
    M_WAIT = 3'b010,
    M_REL = 3'b100
  } rsc_mstate_t;

  function automatic logic rsc_addr_ok(input logic [15:0] w);
    return w <= RSC_ADDR_MAX;
  endfunction : rsc_addr_ok

  function automatic logic rsc_in_link(input logic [15:0] w);
    return (w >= {5'h00, RSC_BASE}) && (w <= {5'h00, RSC_LINK_LAST});
  endfunction : rsc_in_link

  // Zero marks an unknown command code.
  function automatic logic [7:0] rsc_max_count(input logic [7:0] code);
    case (code)
      RSC_CODE_RWRITE: return RSC_MAX_RWRITE;
      RSC_CODE_MONITOR: return RSC_MAX_MONITOR;
      RSC_CODE_PWRITE: return RSC_MAX_PWRITE;
      default: return 8'h00;
    endcase
  endfunction : rsc_max_count
endpackage : rsc_pkg

// >>> core/rsc_link_if.sv
// Purpose: Cyclic link words between master controller and remote station.
// Assumes: Both ends share clk; words are refreshed every cycle.
// Notes: rww command words, rwr response words, rx station bits, ry master bits.
`timescale 1ns/1ps
`default_nettype none
interface rsc_link_if;
  logic [7:0][15:0] rww;
  logic [3:0][15:0] rwr;
  logic [2:0][15:0] rxUser;
  logic [15:0] rxStatus;
  logic [2:0][15:0] ryUser;
  logic [15:0] ryCmd;

  modport station (
    input rww,
    input ryUser,
    input ryCmd,
    output rwr,
    output rxUser,
    output rxStatus
  );

  modport master (
    output rww,
    output ryUser,
    output ryCmd,
    input rwr,
    input rxUser,
    input rxStatus
  );
endinterface : rsc_link_if
`default_nettype wire

// >>> core/rsc_station.sv
// Purpose: Remote station end: command execution on the station word memory.
// Assumes: Master holds command words stable while the display request is high.
// Notes: One command entry per cycle; memory has a single write port.
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module rsc_station
  import rsc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  rsc_link_if.station link,
  input wire logic usrWe,
  input wire logic [10:0] usrAddr,
  input wire logic [15:0] usrWdata,
  output logic [15:0] usrRdata,
  input wire logic touchDone,
  input wire logic tagRequest,
  input wire logic initDone,
  output logic initRequest,
  output logic monStrobe,
  output logic [10:0] monAddr,
  output logic [15:0] monData
);
  typedef struct packed {
    rsc_sstate_t state;
    logic [7:0] code;
    logic [7:0] count;
    logic [3:0] idx;
    logic [5:0][10:0] monList;
    logic [2:0] monCount;
    logic [2:0] monIdx;
    logic [2:0][10:0] pwList;
    logic [1:0] pwCount;
    logic [1:0] pwIdx;
    logic [2:0][15:0] pwShadow;
    logic [1:0] ryIdx;
    logic reqPrev;
    logic erstPrev;
    logic err;
    logic [15:0] errCode;
    logic [15:0] status;
    logic [2:0][15:0] rxUser;
    logic [15:0] usrRdata;
    logic initReq;
    logic monStrobe;
    logic [10:0] monAddr;
    logic [15:0] monData;
  } rsc_station_t;

  localparam rsc_station_t RSC_ST_RESET = '{state: ST_IDLE, default: '0};

  logic [15:0] mem [RSC_WORDS];
  rsc_station_t s;
  rsc_station_t next_s;
  logic memWe;
  logic [10:0] memAddr;
  logic [15:0] memData;

  always_comb begin
    logic [15:0] aw;
    logic [15:0] dw;
    logic failNow;
    logic [15:0] failCode;
    logic last;
    next_s = s;
    aw = 16'h0000;
    dw = 16'h0000;
    failNow = 1'b0;
    failCode = 16'h0000;
    last = ({4'h0, s.idx} + 8'h01) == s.count;
    memWe = 1'b0;
    memAddr = 11'h000;
    memData = 16'h0000;
    next_s.monStrobe = 1'b0;
    next_s.reqPrev = link.ryCmd[RQB_DISP];
    next_s.erstPrev = link.ryCmd[RQB_ERST];
    next_s.initReq = link.ryCmd[RQB_INIT];
    if (link.ryCmd[RQB_ERST] && !s.erstPrev) begin
      next_s.err = 1'b0;
      next_s.errCode = 16'h0000;
    end
    unique case (s.state)
      ST_IDLE: begin
        if (link.ryCmd[RQB_DISP] && !s.reqPrev) begin
          next_s.code = link.rww[0][15:8];
          next_s.count = link.rww[0][7:0];
          next_s.idx = 4'h0;
          if (rsc_max_count(link.rww[0][15:8]) == 8'h00) begin
            failNow = 1'b1;
            failCode = RSC_ERR_CODE;
          end else if (link.rww[0][7:0] == 8'h00 ||
                       link.rww[0][7:0] > rsc_max_count(link.rww[0][15:8])) begin
            failNow = 1'b1;
            failCode = RSC_ERR_COUNT;
          end else begin
            next_s.state = ST_EXEC;
            if (link.rww[0][15:8] == RSC_CODE_MONITOR) begin
              next_s.monCount = 3'h0;
              next_s.monIdx = 3'h0;
            end
            if (link.rww[0][15:8] == RSC_CODE_PWRITE) begin
              next_s.pwCount = 2'h0;
              next_s.pwIdx = 2'h0;
            end
          end
        end else if (s.pwCount != 2'h0 && link.ryCmd[RQB_PW]) begin
          if (link.rww[s.pwIdx] != s.pwShadow[s.pwIdx]) begin
            memWe = 1'b1;
            memAddr = s.pwList[s.pwIdx];
            memData = link.rww[s.pwIdx];
            next_s.pwShadow[s.pwIdx] = link.rww[s.pwIdx];
          end
          next_s.pwIdx = (s.pwIdx + 2'h1 == s.pwCount) ? 2'h0 : s.pwIdx + 2'h1;
        end
      end
      ST_EXEC: begin
        if (s.code == RSC_CODE_RWRITE) begin
          aw = link.rww[{s.idx[2:0], 1'b1}];
          dw = link.rww[{s.idx[2:0], 1'b0} + 4'h2];
        end else begin
          aw = link.rww[s.idx[2:0] + 3'h1];
        end
        if (!rsc_addr_ok(aw)) begin
          failNow = 1'b1;
          failCode = RSC_ERR_ADDR;
        end else if (s.code != RSC_CODE_MONITOR && rsc_in_link(aw)) begin
          failNow = 1'b1;
          failCode = RSC_ERR_LINK;
        end else begin
          unique case (s.code)
            RSC_CODE_RWRITE: begin
              memWe = 1'b1;
              memAddr = aw[10:0];
              memData = dw;
            end
            RSC_CODE_MONITOR: next_s.monList[s.idx[2:0]] = aw[10:0];
            default: next_s.pwList[s.idx[1:0]] = aw[10:0];
          endcase
          next_s.idx = s.idx + 4'h1;
          if (last) begin
            next_s.state = ST_DONE;
            if (s.code == RSC_CODE_MONITOR) begin
              next_s.monCount = s.count[2:0];
            end
            if (s.code == RSC_CODE_PWRITE) begin
              next_s.pwCount = s.count[1:0];
              next_s.pwShadow = link.rww[2:0];
            end
          end
        end
      end
      ST_DONE: begin
        if (!link.ryCmd[RQB_DISP]) begin
          next_s.state = ST_IDLE;
        end
      end
    endcase
    if (failNow) begin
      next_s.err = 1'b1;
      next_s.errCode = failCode;
      next_s.state = ST_DONE;
    end
    if (!memWe) begin
      memWe = 1'b1;
      if (usrWe) begin
        memAddr = usrAddr;
        memData = usrWdata;
      end else begin
        memAddr = RSC_BASE + RSC_OFS_RY + {9'h000, s.ryIdx};
        memData = link.ryUser[s.ryIdx];
        next_s.ryIdx = (s.ryIdx == 2'h2) ? 2'h0 : s.ryIdx + 2'h1;
      end
    end
    // Monitored words stream out to the display side while monitoring is asked.
    if (link.ryCmd[RQB_MON] && s.monCount != 3'h0) begin
      next_s.monStrobe = 1'b1;
      next_s.monAddr = s.monList[s.monIdx];
      next_s.monData = mem[s.monList[s.monIdx]];
      next_s.monIdx = (s.monIdx + 3'h1 == s.monCount) ? 3'h0 : s.monIdx + 3'h1;
    end
    for (int i = 0; i < 3; i++) begin
      next_s.rxUser[i] = mem[RSC_BASE + 11'(i)];
    end
    next_s.usrRdata = mem[usrAddr];
    next_s.status = 16'h0000;
    next_s.status[STB_DONE] = (next_s.state == ST_DONE);
    next_s.status[STB_TOUCH] = touchDone;
    next_s.status[STB_TAG] = tagRequest;
    next_s.status[STB_INIT] = initDone;
    next_s.status[STB_ERR] = next_s.err;
    next_s.status[STB_READY] = 1'b1;
  end

  // The memory has no reset; its contents are the user's business after power-up.
  always_ff @(posedge clk) begin
    if (ce && memWe) begin
      mem[memAddr] <= memData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= RSC_ST_RESET;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign link.rwr = {48'h0, s.errCode};
  assign link.rxUser = s.rxUser;
  assign link.rxStatus = s.status;
  assign usrRdata = s.usrRdata;
  assign initRequest = s.initReq;
  assign monStrobe = s.monStrobe;
  assign monAddr = s.monAddr;
  assign monData = s.monData;
endmodule : rsc_station
`default_nettype wire

// >>> core/rsc_master.sv
// Purpose: Master controller end: APB registers drive the command sequence.
// Assumes: Software loads command words before writing the go bit.
// Notes: Every APB access takes one wait cycle.
`timescale 1ns/1ps
`default_nettype none
module rsc_master
  import rsc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  rsc_link_if.master link
);
  typedef struct packed {
    rsc_mstate_t state;
    logic [7:0][15:0] cmd;
    logic [2:0][15:0] userOut;
    logic pwEn;
    logic monEn;
    logic initEn;
    logic reqDisp;
    logic pwReq;
    logic erst;
    logic errPrev;
    logic tagPrev;
    logic [2:0] intStat;
    logic [2:0] intMask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [15:0] ryCmd;
  } rsc_master_t;

  localparam rsc_master_t RSC_M_RESET = '{state: M_IDLE, default: '0};

  rsc_master_t s;
  rsc_master_t next_s;

  always_comb begin
    logic fin;
    logic go;
    logic [2:0] ev;
    next_s = s;
    fin = psel && penable && s.pready;
    go = 1'b0;
    ev = 3'h0;
    next_s.pready = 1'b0;
    next_s.erst = 1'b0;
    // First access cycle: answer is prepared, side effects wait for the final edge.
    if (psel && penable && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.pslverr = 1'b0;
      next_s.prdata = 32'h0000_0000;
      if (paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0) begin
        next_s.prdata[15:0] = s.cmd[paddr[4:2]];
      end else if (paddr == RSC_A_USERIN0 || paddr == RSC_A_USERIN0 + 8'h04 ||
                   paddr == RSC_A_USERIN0 + 8'h08) begin
        next_s.prdata[15:0] = link.rxUser[paddr[3:2]];
      end else if (paddr == RSC_A_USEROUT0 || paddr == RSC_A_USEROUT0 + 8'h04 ||
                   paddr == RSC_A_USEROUT0 + 8'h08) begin
        next_s.prdata[15:0] = s.userOut[paddr[3:2]];
      end else begin
        unique case (paddr)
          RSC_A_CTRL: begin
            next_s.prdata[CTB_PW] = s.pwEn;
            next_s.prdata[CTB_MON] = s.monEn;
            next_s.prdata[CTB_INIT] = s.initEn;
          end
          RSC_A_STATUS: begin
            next_s.prdata[15:0] = link.rxStatus;
            next_s.prdata[STB_BUSY] = (s.state != M_IDLE);
          end
          RSC_A_RESP: next_s.prdata[15:0] = link.rwr[0];
          RSC_A_INTSTAT: next_s.prdata[2:0] = s.intStat;
          RSC_A_INTMASK: next_s.prdata[2:0] = s.intMask;
          default: next_s.pslverr = 1'b1;
        endcase
      end
    end
    if (fin && !s.pslverr) begin
      if (pwrite) begin
        if (paddr[7:5] == 3'h0) begin
          next_s.cmd[paddr[4:2]] = pwdata[15:0];
        end else if (paddr[7:4] == RSC_A_USEROUT0[7:4]) begin
          next_s.userOut[paddr[3:2]] = pwdata[15:0];
        end else if (paddr == RSC_A_CTRL) begin
          go = pwdata[CTB_GO];
          next_s.pwEn = pwdata[CTB_PW];
          next_s.monEn = pwdata[CTB_MON];
          next_s.initEn = pwdata[CTB_INIT];
          next_s.erst = pwdata[CTB_ERST];
        end else if (paddr == RSC_A_INTMASK) begin
          next_s.intMask = pwdata[2:0];
        end
      end else if (paddr == RSC_A_INTSTAT) begin
        next_s.intStat = 3'h0;
      end
    end
    unique case (s.state)
      M_IDLE: begin
        if (go) begin
          next_s.reqDisp = 1'b1;
          next_s.state = M_WAIT;
        end
      end
      M_WAIT: begin
        if (link.rxStatus[STB_DONE]) begin
          next_s.reqDisp = 1'b0;
          next_s.pwReq = next_s.pwEn;
          ev[INB_DONE] = 1'b1;
          next_s.state = M_REL;
        end
      end
      M_REL: begin
        if (!link.rxStatus[STB_DONE]) begin
          next_s.state = M_IDLE;
        end
      end
    endcase
    // Dropping the enable stops periodic writing at once.
    if (!next_s.pwEn) begin
      next_s.pwReq = 1'b0;
    end
    next_s.errPrev = link.rxStatus[STB_ERR];
    next_s.tagPrev = link.rxStatus[STB_TAG];
    ev[INB_ERR] = link.rxStatus[STB_ERR] && !s.errPrev;
    ev[INB_TAG] = link.rxStatus[STB_TAG] && !s.tagPrev;
    // A new event beats the read that clears it.
    next_s.intStat = next_s.intStat | ev;
    next_s.irq = |(next_s.intStat & next_s.intMask);
    next_s.ryCmd = 16'h0000;
    next_s.ryCmd[RQB_DISP] = next_s.reqDisp;
    next_s.ryCmd[RQB_MON] = next_s.monEn;
    next_s.ryCmd[RQB_PW] = next_s.pwReq;
    next_s.ryCmd[RQB_INIT] = next_s.initEn;
    next_s.ryCmd[RQB_ERST] = next_s.erst;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= RSC_M_RESET;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign irq = s.irq;
  assign link.rww = s.cmd;
  assign link.ryUser = s.userOut;
  assign link.ryCmd = s.ryCmd;
endmodule : rsc_master
`default_nettype wire

// >>> verif/rsc_checker.sv
// Purpose: Link-level assertions between the master and station ends.
// Assumes: One clock; a low reset clears both ends.
// Notes: Bounds carry a little slack over the hand-over figures.
`timescale 1ns/1ps
`default_nettype none
module rsc_checker
  import rsc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0][15:0] rww,
  input wire logic [3:0][15:0] rwr,
  input wire logic [2:0][15:0] rxUser,
  input wire logic [15:0] rxStatus,
  input wire logic [2:0][15:0] ryUser,
  input wire logic [15:0] ryCmd
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_status_reserved: assert property ((rxStatus & 16'hF15E) == 16'h0000)
    else $error("reserved status bit set");
  a_resp_unused: assert property ({rwr[3], rwr[2], rwr[1]} == 48'h0)
    else $error("unused response word set");
  a_cmd_reserved: assert property ((ryCmd & 16'hF9F8) == 16'h0000)
    else $error("reserved command bit set");
  a_done_needs_req: assert property ($rose(rxStatus[STB_DONE]) |-> ryCmd[RQB_DISP])
    else $error("complete without request");
  a_done_in_time: assert property ($rose(ryCmd[RQB_DISP]) |-> ##[1:12] rxStatus[STB_DONE])
    else $error("complete late");
  a_req_holds: assert property (ryCmd[RQB_DISP] && !rxStatus[STB_DONE] |=> ryCmd[RQB_DISP])
    else $error("request dropped early");
  a_req_drops: assert property (rxStatus[STB_DONE] && ryCmd[RQB_DISP]
    |-> ##[1:2] !ryCmd[RQB_DISP])
    else $error("request not dropped");
  a_done_drops: assert property ($fell(ryCmd[RQB_DISP]) |-> ##[1:3] !rxStatus[STB_DONE])
    else $error("complete not dropped");
  a_err_has_code: assert property ($rose(rxStatus[STB_ERR]) |-> ##[0:2] (rwr[0] != 16'h0))
    else $error("error flag without code");
  a_err_reset: assert property (ryCmd[RQB_ERST] && !ryCmd[RQB_DISP]
    |-> ##[1:3] !rxStatus[STB_ERR])
    else $error("error flag not cleared");
  a_ready_keeps: assert property (rxStatus[STB_READY] |=> rxStatus[STB_READY])
    else $error("ready lost");
  a_pw_after_done: assert property ($rose(ryCmd[RQB_PW]) |-> rxStatus[STB_DONE])
    else $error("periodic request before complete");
endmodule : rsc_checker
`default_nettype wire

// >>> verif/tb.sv
// Purpose: Self-checking bench of master and station joined by the link.
// Assumes: ce tied high; memory words are written before they are read back.
// Notes: Every wait is bounded by the cycle ceiling.
`timescale 1ns/1ps
`default_nettype none
module tb
  import rsc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic usrWe = 1'b0;
  logic [10:0] usrAddr = 11'h000;
  logic [15:0] usrWdata = 16'h0000;
  logic touchDone = 1'b0;
  logic tagRequest = 1'b0;
  logic initDone = 1'b0;
  logic [31:0] prdata, rv;
  logic pready, pslverr, irq, ev, initRequest, monStrobe;
  logic [15:0] usrRdata, monData;
  logic [10:0] monAddr;
  int failCount = 0;
  int checksDone = 0;
  int cycles = 0;
  rsc_link_if link();
  rsc_master u_rsc_master (.clk(clk), .rst_n(rst_n), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .link(link));
  rsc_station u_rsc_station (.clk(clk), .rst_n(rst_n), .ce(1'b1), .link(link),
    .usrWe(usrWe), .usrAddr(usrAddr), .usrWdata(usrWdata), .usrRdata(usrRdata),
    .touchDone(touchDone), .tagRequest(tagRequest), .initDone(initDone),
    .initRequest(initRequest), .monStrobe(monStrobe), .monAddr(monAddr), .monData(monData));
  rsc_checker u_rsc_checker (.clk(clk), .rst_n(rst_n), .rww(link.rww), .rwr(link.rwr),
    .rxUser(link.rxUser), .rxStatus(link.rxStatus), .ryUser(link.ryUser), .ryCmd(link.ryCmd));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failCount++;
      $display("mismatch at %0t: timeout", $time);
      closeOut();
    end
  end
  task automatic closeOut();
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : closeOut
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    checksDone++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask : chk
  // The request stands until pready is seen high at a rising edge; only the bench
  // timeout ends a wait that never gets its answer.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string s);
    apb(1'b0, a, 32'h0, rv, ev);
    chk(rv, e, s);
  endtask : rchk
  task automatic ichk(input logic e);
    @(negedge clk);
    chk(32'(irq), 32'(e), "irq");
    @(posedge clk);
  endtask : ichk
  task automatic mwr(input logic [10:0] a, input logic [15:0] d);
    usrWe <= 1'b1;
    usrAddr <= a;
    usrWdata <= d;
    @(posedge clk);
    usrWe <= 1'b0;
    @(posedge clk);
  endtask : mwr
  task automatic mchk(input logic [10:0] a, input logic [15:0] d);
    usrAddr <= a;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(32'(usrRdata), 32'(d), "memory word");
    @(posedge clk);
  endtask : mchk
  task automatic cmd(input logic [15:0] w [7], input logic [31:0] ctrl);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 7; i++) apb(1'b1, RSC_A_CMD0 + 8'(4 * i), 32'(w[i]), rv, ev);
    apb(1'b1, RSC_A_CTRL, ctrl, rv, ev);
    for (int n = 0; n < 60; n++) begin
      @(negedge clk);
      if (link.rxStatus[STB_DONE] === 1'b1) seen = 1'b1;
      else if (seen) break;
    end
    @(posedge clk);
    chk(32'(seen), 32'h1, "complete seen");
  endtask : cmd
  task automatic t_map();
    touchDone <= 1'b1;
    tagRequest <= 1'b1;
    initDone <= 1'b1;
    for (int i = 0; i < 3; i++) mwr(RSC_BASE + 11'(i), 16'hC000 + 16'(i));
    for (int i = 0; i < 3; i++) rchk(RSC_A_USERIN0 + 8'(4 * i), 32'hC000 + i, "in");
    for (int i = 0; i < 3; i++) apb(1'b1, RSC_A_USEROUT0 + 8'(4 * i), 32'hD000 + i, rv, ev);
    for (int i = 0; i < 3; i++) mchk(RSC_BASE + RSC_OFS_RY + 11'(i), 16'hD000 + 16'(i));
    rchk(RSC_A_STATUS, 32'h0AA0, "status");
    rchk(RSC_A_INTSTAT, 32'h4, "tag event");
    apb(1'b0, 8'h60, 32'h0, rv, ev);
    chk(32'(ev), 32'h1, "unmapped");
    apb(1'b1, RSC_A_CTRL, 32'h10, rv, ev);
    rchk(RSC_A_CTRL, 32'h10, "control readback");
    chk(32'(initRequest), 32'h1, "init request");
    apb(1'b1, RSC_A_CTRL, 32'h0, rv, ev);
    @(negedge clk);
    chk(32'(initRequest), 32'h0, "init released");
    @(posedge clk);
  endtask : t_map
  task automatic t_rwrite();
    mwr(11'd25, 16'hA5A5);
    apb(1'b1, RSC_A_INTMASK, 32'h2, rv, ev);
    cmd('{16'h0503, 16'd0, 16'd1, 16'd1100, 16'd2, 16'd1979, 16'd3}, 32'h1);
    mchk(11'd0, 16'd1);
    mchk(11'd1100, 16'd2);
    mchk(11'd1979, 16'd3);
    rchk(RSC_A_RESP, 32'h0, "no error");
    ichk(1'b0);
    rchk(RSC_A_INTSTAT, 32'h1, "done event");
    cmd('{16'h0501, 16'd25, 16'h5A5A, 16'd0, 16'd0, 16'd0, 16'd0}, 32'h1);
    mchk(11'd25, 16'hA5A5);
    rchk(RSC_A_RESP, 32'(RSC_ERR_LINK), "link code");
    ichk(1'b1);
    rchk(RSC_A_INTSTAT, 32'h3, "error event");
    ichk(1'b0);
    apb(1'b1, RSC_A_CTRL, 32'h8, rv, ev);
    rchk(RSC_A_STATUS, 32'h0AA0, "error reset");
  endtask : t_rwrite
  task automatic t_bad();
    logic [15:0] hw [7] = '{16'h0701, 16'h0504, 16'h0500, 16'h0607, 16'h0804, 16'h0501,
      16'h0801};
    logic [15:0] aw [7] = '{16'd100, 16'd100, 16'd100, 16'd100, 16'd100, 16'd2032, 16'd30};
    logic [15:0] ew [7] = '{RSC_ERR_CODE, RSC_ERR_COUNT, RSC_ERR_COUNT, RSC_ERR_COUNT,
      RSC_ERR_COUNT, RSC_ERR_ADDR, RSC_ERR_LINK};
    for (int i = 0; i < 7; i++) begin
      cmd('{hw[i], aw[i], 16'd7, 16'd101, 16'd7, 16'd102, 16'd7}, 32'h1);
      rchk(RSC_A_RESP, 32'(ew[i]), "error code");
      rchk(RSC_A_STATUS, 32'h0EA0, "error flag");
      apb(1'b1, RSC_A_CTRL, 32'h8, rv, ev);
      rchk(RSC_A_STATUS, 32'h0AA0, "cleared");
    end
  endtask : t_bad
  task automatic t_monitor();
    int n;
    n = 0;
    for (int i = 0; i < 6; i++) mwr(11'd100 + 11'(i), 16'h1000 + 16'(i));
    cmd('{16'h0606, 16'd100, 16'd101, 16'd102, 16'd103, 16'd104, 16'd105}, 32'h5);
    rchk(RSC_A_RESP, 32'h0, "no response");
    for (int c = 0; c < 40; c++) begin
      @(negedge clk);
      if (monStrobe === 1'b1) begin
        n++;
        chk(32'(monAddr >= 11'd100 && monAddr <= 11'd105), 32'h1, "mon addr");
        chk(32'(monData), 32'h1000 + 32'(monAddr - 11'd100), "mon data");
      end
    end
    @(posedge clk);
    chk(32'(n >= 6), 32'h1, "mon count");
  endtask : t_monitor
  task automatic t_periodic();
    cmd('{16'h0803, 16'd100, 16'd1100, 16'd2031, 16'd0, 16'd0, 16'd0}, 32'h3);
    @(negedge clk);
    chk(32'(link.ryCmd[RQB_PW]), 32'h1, "periodic request");
    @(posedge clk);
    for (int i = 0; i < 3; i++) apb(1'b1, RSC_A_CMD0 + 8'(4 * i), 32'hBEE0 + i, rv, ev);
    repeat (20) @(posedge clk);
    mchk(11'd100, 16'hBEE0);
    mchk(11'd1100, 16'hBEE1);
    mchk(11'd2031, 16'hBEE2);
  endtask : t_periodic
  initial begin
    repeat (5) @(posedge clk);
    chk(32'(link.ryCmd), 32'h0, "reset command bits");
    rst_n <= 1'b1;
    @(posedge clk);
    t_map();
    t_rwrite();
    t_bad();
    t_monitor();
    t_periodic();
    closeOut();
  end
endmodule : tb
`default_nettype wire
